// [rtl/gtpms_pkg.sv]
// Package with constants and types shared by the general-purpose timer block.
package gtpms_pkg;

    // Configuration values for the global timer width and function.
    localparam logic [2:0] GTPMS_CFG_32BIT = 3'h0;
    localparam logic [2:0] GTPMS_CFG_RTC   = 3'h1;
    localparam logic [2:0] GTPMS_CFG_16BIT = 3'h4;

    // Timer mode field encodings.
    localparam logic [1:0] GTPMS_TMR_ONESHOT  = 2'h1;
    localparam logic [1:0] GTPMS_TMR_PERIODIC = 2'h2;
    localparam logic [1:0] GTPMS_TMR_CAPTURE  = 2'h3;

    // Edge event field encodings.
    localparam logic [1:0] GTPMS_EVT_RISE = 2'h0;
    localparam logic [1:0] GTPMS_EVT_FALL = 2'h1;
    localparam logic [1:0] GTPMS_EVT_BOTH = 2'h3;

    // Bit positions inside the raw and masked status vectors.
    localparam int GTPMS_ST_TIMEOUT = 0;
    localparam int GTPMS_ST_MATCH   = 1;
    localparam int GTPMS_ST_CAPTURE = 2;
    localparam int GTPMS_ST_RTC     = 3;
    localparam int GTPMS_ST_W       = 4;

    // Reset and start values, and the low-half mask.
    localparam logic [31:0] GTPMS_COUNT_RESET = 32'hffff_ffff;
    localparam logic [31:0] GTPMS_RTC_START   = 32'h0000_0001;
    localparam logic [31:0] GTPMS_ZERO        = 32'h0000_0000;
    localparam logic [15:0] GTPMS_LOW_MASK    = 16'hffff;
    localparam logic [7:0]  GTPMS_PRE_RESET   = 8'h00;

    // Decoded operating mode, one-hot.
    typedef enum logic [8:0] {
        GTPMS_M_IDLE      = 9'h001,
        GTPMS_M_ONESHOT32 = 9'h002,
        GTPMS_M_PERIOD32  = 9'h004,
        GTPMS_M_RTC       = 9'h008,
        GTPMS_M_ONESHOT16 = 9'h010,
        GTPMS_M_PERIOD16  = 9'h020,
        GTPMS_M_EDGECNT   = 9'h040,
        GTPMS_M_EDGETIME  = 9'h080,
        GTPMS_M_PWM       = 9'h100
    } gtpms_mode_t;

endpackage : gtpms_pkg

// [rtl/gtpms_edge_sync.sv]
// Synchroniser and edge qualifier for the capture/compare pin.
`timescale 1ns/1ps
module gtpms_edge_sync (
    // Clock, reset and enable.
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    // Pin and edge selection.
    input  wire logic       pin,
    input  wire logic [1:0] edge_sel,
    // Qualified edges.
    output logic            rise,
    output logic            event_hit
);
    import gtpms_pkg::*;

    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       fall;

    // Shift the pin through two synchroniser stages and one history stage.
    always_comb begin
        sync_d = clk_en ? {sync_q[1:0], pin} : sync_q;
    end

    // Registers only; the first stage feeds nothing but the second.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= sync_d;
        end
    end

    // Compare the two synchronised samples against the selected edge type.
    always_comb begin
        rise      = sync_q[1] & ~sync_q[2];                        // [R26]
        fall      = ~sync_q[1] & sync_q[2];
        event_hit = 1'b0;
        unique case (edge_sel)
            GTPMS_EVT_RISE: event_hit = rise;                      // [R14]
            GTPMS_EVT_FALL: event_hit = fall;
            GTPMS_EVT_BOTH: event_hit = rise | fall;
            default:        event_hit = 1'b0;
        endcase
    end

endmodule : gtpms_edge_sync

// [rtl/gtpms_timer.sv]
// General-purpose timer: 32/16-bit one-shot and periodic, RTC, edge count, edge time, PWM.
`timescale 1ns/1ps

// How it works
// [R1] PWM: alternate=1, capture=0, mode=2.
// [R2] PWM counts down, reloads, runs until disabled.
// [R3] PWM mode raises no flag.
// [R4] PWM active at start, inactive at match.
// [R5] Invert bit flips PWM polarity.
// [R6] Prescaler unused in PWM mode.
// [R7] Config 0: mode 1 one-shot, 2 periodic.
// [R8] Timeout sets flag; clear bit clears it.
// [R9] One-shot stops after timeout; periodic continues.
// [R10] Config 1 is RTC, pin clocks it.
// [R11] RTC match sets flag, counting continues.
// [R12] Config 4 16-bit, prescaler extends range.
// [R13] Edge count: capture=0, mode=3, 16-bit.
// [R14] Edge field selects counted or captured edge.
// [R15] Edge count stops after programmed edges.
// [R16] Count-match clear bit clears its flag.
// [R17] Edge time: capture=1, mode=3, 16-bit.
// [R18] Edge time captures count, sets flag.
// [R19] Edge time runs on; load applies next cycle.
// [R20] PWM load write changes period next cycle.
// [R21] Software disables timer before reconfiguring.
// [R22] Software enables timer clock gate first.
// [R23] 16-bit one-shot reloads, stops, clears enable.
// [R24] Each edge decrements until count equals match.
// [R25] Interrupt when any unmasked raw flag set.
// [R26] Capture pin synchronised before edge compare.
module gtpms_timer #(
    parameter int CNT_W = 32,
    parameter int PRE_W = 8
) (
    // Clock, reset and clock enable.
    input  wire logic                            clk,
    input  wire logic                            reset,
    input  wire logic                            clk_en,
    // Configuration and mode.
    input  wire logic [2:0]                      timer_configuration,
    input  wire logic                            alternate_mode_select,
    input  wire logic                            capture_mode_select,
    input  wire logic [1:0]                      timer_mode_field,
    // Control.
    input  wire logic                            timer_enable_set,
    input  wire logic                            timer_enable_clear,
    input  wire logic [1:0]                      edge_event_select,
    input  wire logic                            pwm_output_invert,
    // Load, match and prescale values.
    input  wire logic [CNT_W-1:0]                interval_load_value,
    input  wire logic                            interval_load_write,
    input  wire logic [CNT_W-1:0]                match_value,
    input  wire logic [PRE_W-1:0]                prescale_value,
    // Interrupt mask and clear pulses, indexed by status bit position.
    input  wire logic [gtpms_pkg::GTPMS_ST_W-1:0] interrupt_mask,
    input  wire logic [gtpms_pkg::GTPMS_ST_W-1:0] interrupt_clear,
    // External capture/compare pin.
    input  wire logic                            capture_compare_pin,
    // Status and results.
    output logic                                 timer_enable_bit,
    output logic [gtpms_pkg::GTPMS_ST_W-1:0]     raw_interrupt_status,
    output logic [gtpms_pkg::GTPMS_ST_W-1:0]     masked_interrupt_status,
    output logic                                 timer_interrupt,
    output logic [CNT_W-1:0]                     current_count,
    output logic [CNT_W-1:0]                     captured_count,
    output logic                                 pwm_out
);
    import gtpms_pkg::*;

    gtpms_mode_t               mode;
    logic                      rtc_rise;
    logic                      edge_hit;
    logic                      en_q;
    logic                      en_d;
    logic [CNT_W-1:0]          cnt_q;
    logic [CNT_W-1:0]          cnt_d;
    logic [CNT_W-1:0]          cap_q;
    logic [CNT_W-1:0]          cap_d;
    logic [PRE_W-1:0]          pre_q;
    logic [PRE_W-1:0]          pre_d;
    logic [GTPMS_ST_W-1:0]     raw_q;
    logic [GTPMS_ST_W-1:0]     raw_d;
    logic [GTPMS_ST_W-1:0]     set_ev;
    logic [GTPMS_ST_W-1:0]     mis_q;
    logic                      irq_q;
    logic                      pwm_q;
    logic                      pwm_d;
    logic                      pwm_act;
    logic [CNT_W-1:0]          load16;
    logic [CNT_W-1:0]          match16;
    logic [CNT_W-1:0]          load_sel;
    logic [CNT_W-1:0]          dec;
    logic                      auto_clr;
    logic                      start;

    // Pin conditioning; the RTC input always counts rising edges.
    gtpms_edge_sync u_edge (
        .clk       (clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .pin       (capture_compare_pin),
        .edge_sel  (edge_event_select),
        .rise      (rtc_rise),
        .event_hit (edge_hit)
    );

    // Decode the configuration and mode fields into one operating mode.
    // Configurations 2 and 3 fall into idle; 5 to 7 decode like 4, since only bit 2 is tested.
    always_comb begin
        mode = GTPMS_M_IDLE;
        if (timer_configuration == GTPMS_CFG_32BIT) begin
            if (timer_mode_field == GTPMS_TMR_ONESHOT) begin
                mode = GTPMS_M_ONESHOT32;                          // [R7]
            end else if (timer_mode_field == GTPMS_TMR_PERIODIC) begin
                mode = GTPMS_M_PERIOD32;                           // [R7]
            end
        end else if (timer_configuration == GTPMS_CFG_RTC) begin
            mode = GTPMS_M_RTC;                                    // [R10]
        end else if (timer_configuration[2]) begin
            if (alternate_mode_select && !capture_mode_select
                && timer_mode_field == GTPMS_TMR_PERIODIC) begin
                mode = GTPMS_M_PWM;                                // [R1]
            end else if (timer_mode_field == GTPMS_TMR_CAPTURE) begin
                mode = capture_mode_select ? GTPMS_M_EDGETIME      // [R17]
                                           : GTPMS_M_EDGECNT;      // [R13]
            end else if (timer_mode_field == GTPMS_TMR_ONESHOT) begin
                mode = GTPMS_M_ONESHOT16;                          // [R12]
            end else if (timer_mode_field == GTPMS_TMR_PERIODIC) begin
                mode = GTPMS_M_PERIOD16;                           // [R12]
            end
        end
    end

    // Sixteen-bit modes only see the low half of load and match.
    assign load16  = interval_load_value & CNT_W'(GTPMS_LOW_MASK);
    assign match16 = match_value & CNT_W'(GTPMS_LOW_MASK);
    assign dec     = cnt_q - CNT_W'(1);

    // Counter, prescaler, enable and capture next-state logic.
    always_comb begin
        cnt_d    = cnt_q;
        pre_d    = pre_q;
        cap_d    = cap_q;
        set_ev   = '0;
        auto_clr = 1'b0;
        start    = timer_enable_set && !en_q && !timer_enable_clear;
        load_sel = (mode == GTPMS_M_ONESHOT32 || mode == GTPMS_M_PERIOD32)
                   ? interval_load_value : load16;
        if (start) begin
            // Enabling loads the start value, so PWM starts in its active state.
            cnt_d = (mode == GTPMS_M_RTC) ? CNT_W'(GTPMS_RTC_START) : load_sel;
            pre_d = prescale_value;
        end else if (en_q) begin
            unique case (mode)
                GTPMS_M_ONESHOT32, GTPMS_M_PERIOD32,
                GTPMS_M_ONESHOT16, GTPMS_M_PERIOD16: begin
                    if (interval_load_write) begin
                        cnt_d = load_sel;
                    end else if (pre_q != '0 && (mode == GTPMS_M_ONESHOT16
                                 || mode == GTPMS_M_PERIOD16)) begin
                        pre_d = pre_q - PRE_W'(1);                 // [R12]
                    end else if (cnt_q == '0) begin
                        // Zero is held one tick, then the start value returns.
                        cnt_d = load_sel;
                        pre_d = prescale_value;
                        set_ev[GTPMS_ST_TIMEOUT] = 1'b1;           // [R8]
                        auto_clr = (mode == GTPMS_M_ONESHOT32)     // [R9]
                                || (mode == GTPMS_M_ONESHOT16);    // [R23]
                    end else begin
                        cnt_d = dec;
                        pre_d = prescale_value;
                    end
                end
                GTPMS_M_RTC: begin
                    if (rtc_rise) begin
                        if (cnt_q == match_value) begin
                            cnt_d = '0;
                            set_ev[GTPMS_ST_RTC] = 1'b1;           // [R11]
                        end else begin
                            cnt_d = cnt_q + CNT_W'(1);
                        end
                    end
                end
                GTPMS_M_EDGECNT: begin
                    if (edge_hit) begin
                        if (dec == match16) begin
                            cnt_d = load16;                        // [R15]
                            set_ev[GTPMS_ST_MATCH] = 1'b1;         // [R24]
                            auto_clr = 1'b1;                       // [R15]
                        end else begin
                            cnt_d = dec;                           // [R24]
                        end
                    end
                end
                GTPMS_M_EDGETIME: begin
                    if (edge_hit) begin
                        cap_d = cnt_q;                             // [R18]
                        set_ev[GTPMS_ST_CAPTURE] = 1'b1;           // [R18]
                    end
                    if (interval_load_write || cnt_q == '0) begin
                        cnt_d = load16;                            // [R19]
                    end else begin
                        cnt_d = dec;
                    end
                end
                GTPMS_M_PWM: begin
                    // No prescaling and no status events in this mode.
                    if (interval_load_write || cnt_q == '0) begin
                        cnt_d = load16;                            // [R20] [R2]
                    end else begin
                        cnt_d = dec;                               // [R2] [R6] [R3]
                    end
                end
                GTPMS_M_IDLE: begin
                    cnt_d = cnt_q;
                end
            endcase
        end
    end

    // Enable: software clear wins, then software set, then self-clear on finish.
    always_comb begin
        if (timer_enable_clear) begin
            en_d = 1'b0;
        end else if (timer_enable_set) begin
            en_d = 1'b1;
        end else begin
            en_d = en_q && !auto_clr;                              // [R9] [R23]
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    always_comb begin
        raw_d = (raw_q & ~interrupt_clear) | set_ev;               // [R8] [R16] [R11]
    end

    // PWM level: active at the start value, inactive at the match value.
    always_comb begin
        pwm_act = pwm_q ^ pwm_output_invert;
        if (mode != GTPMS_M_PWM || !en_d) begin
            pwm_act = 1'b0;
        end else if (cnt_d == load16) begin
            pwm_act = 1'b1;                                        // [R4]
        end else if (cnt_d == match16) begin
            pwm_act = 1'b0;                                        // [R4]
        end
        pwm_d = pwm_act ^ pwm_output_invert;                       // [R5]
    end

    // Register every piece of state; a low clock enable freezes it all.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            en_q  <= 1'b0;
            cnt_q <= CNT_W'(GTPMS_COUNT_RESET);
            cap_q <= CNT_W'(GTPMS_COUNT_RESET);
            pre_q <= PRE_W'(GTPMS_PRE_RESET);
            raw_q <= '0;
            mis_q <= '0;
            irq_q <= 1'b0;
            pwm_q <= 1'b0;
        end else if (clk_en) begin
            en_q  <= en_d;
            cnt_q <= cnt_d;
            cap_q <= cap_d;
            pre_q <= pre_d;
            raw_q <= raw_d;
            mis_q <= raw_d & interrupt_mask;                       // [R25]
            irq_q <= |(raw_d & interrupt_mask);                    // [R25]
            pwm_q <= pwm_d;
        end
    end

    // Outputs come straight from the registers above.
    assign timer_enable_bit        = en_q;
    assign raw_interrupt_status    = raw_q;
    assign masked_interrupt_status = mis_q;
    assign timer_interrupt         = irq_q;
    assign current_count           = cnt_q;
    assign captured_count          = cap_q;
    assign pwm_out                 = pwm_q;

endmodule : gtpms_timer

// [bench/gtpms_pin_model.sv]
// Model of the outside party that drives the capture/compare pin.
`timescale 1ns/1ps
module gtpms_pin_model (
    // Clock and run control.
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [8:0] half,
    // Pin towards the timer.
    output logic            pin = 1'b0
);
    logic [8:0] cnt_q = 9'h0;

    // Toggle every half period while running; the pin holds its level when stopped.
    always @(posedge clk) begin
        if (!run) begin
            cnt_q <= 9'h0;
        end else if (cnt_q + 9'h1 >= half) begin
            cnt_q <= 9'h0;
            pin   <= !pin;
        end else begin
            cnt_q <= cnt_q + 9'h1;
        end
    end
endmodule : gtpms_pin_model

// [bench/gtpms_timer_monitor.sv]
// Concurrent checks on the ports of the timer.
`timescale 1ns/1ps
module gtpms_timer_monitor import gtpms_pkg::*; #(
    parameter int CNT_W = 32
) (
    // Clock, reset and configuration.
    input wire logic                             clk,
    input wire logic                             reset,
    input wire logic                             clk_en,
    input wire logic [2:0]                       timer_configuration,
    input wire logic                             alternate_mode_select,
    input wire logic                             capture_mode_select,
    input wire logic [1:0]                       timer_mode_field,
    input wire logic                             timer_enable_clear,
    input wire logic                             pwm_output_invert,
    input wire logic [CNT_W-1:0]                 interval_load_value,
    input wire logic                             interval_load_write,
    input wire logic [CNT_W-1:0]                 match_value,
    input wire logic [gtpms_pkg::GTPMS_ST_W-1:0] interrupt_mask,
    // Results.
    input wire logic                             timer_enable_bit,
    input wire logic [gtpms_pkg::GTPMS_ST_W-1:0] raw_interrupt_status,
    input wire logic [gtpms_pkg::GTPMS_ST_W-1:0] masked_interrupt_status,
    input wire logic                             timer_interrupt,
    input wire logic [CNT_W-1:0]                 current_count,
    input wire logic [CNT_W-1:0]                 captured_count,
    input wire logic                             pwm_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Mode decodes; loads written mid-run are excluded since they move the count.
    logic cfg32, pwm_on, quiet;
    assign cfg32  = timer_configuration == 3'h0 && timer_enable_bit && ^timer_mode_field;
    assign pwm_on = timer_configuration[2] && alternate_mode_select && !capture_mode_select
                    && timer_mode_field == 2'h2 && timer_enable_bit;
    assign quiet  = clk_en && !interval_load_write && !timer_enable_clear;

    // Steps of the counting and waveform sequences.
    sequence s_at_zero;
        cfg32 && quiet && current_count == '0;
    endsequence
    sequence s_at_start;
        pwm_on && quiet && current_count[15:0] == interval_load_value[15:0]
            && match_value[15:0] + 16'h1 != interval_load_value[15:0];
    endsequence
    sequence s_at_match;
        pwm_on && quiet && current_count[15:0] == match_value[15:0] && match_value[15:0] != 16'h0;
    endsequence

    a_count_down: assert property (cfg32 && quiet && current_count != '0 |=>
        current_count == $past(current_count) - 1) else $error("count did not step down");
    a_wrap_reload: assert property (s_at_zero |=> current_count == $past(interval_load_value)
        && raw_interrupt_status[GTPMS_ST_TIMEOUT]
        && timer_enable_bit == $past(timer_mode_field[1])) else $error("bad timeout step");
    a_pwm_start: assert property (s_at_start ##1 pwm_on |-> pwm_out == !pwm_output_invert)
        else $error("pwm not active after start");
    a_pwm_stop: assert property (s_at_match ##1 pwm_on |-> pwm_out == pwm_output_invert)
        else $error("pwm not inactive after match");
    a_pwm_no_flag: assert property (pwm_on |=>
        (raw_interrupt_status & ~$past(raw_interrupt_status)) == '0) else $error("flag in pwm");
    a_mask_follow: assert property ($past(clk_en) |-> masked_interrupt_status ==
        (raw_interrupt_status & $past(interrupt_mask))) else $error("masked status wrong");
    a_irq_or: assert property ($past(clk_en) |-> timer_interrupt == |masked_interrupt_status)
        else $error("interrupt not the or of masked status");
    a_capture_flag: assert property ($changed(captured_count) |->
        raw_interrupt_status[GTPMS_ST_CAPTURE]) else $error("capture without flag");
    a_freeze_hold: assert property (!clk_en |=> $stable(current_count)
        && $stable(raw_interrupt_status)) else $error("state moved while frozen");
endmodule : gtpms_timer_monitor

bind gtpms_timer gtpms_timer_monitor #(.CNT_W(CNT_W)) u_monitor (.clk(clk), .reset(reset),
    .clk_en(clk_en), .timer_configuration(timer_configuration),
    .alternate_mode_select(alternate_mode_select), .capture_mode_select(capture_mode_select),
    .timer_mode_field(timer_mode_field), .timer_enable_clear(timer_enable_clear),
    .pwm_output_invert(pwm_output_invert), .interval_load_value(interval_load_value),
    .interval_load_write(interval_load_write), .match_value(match_value),
    .interrupt_mask(interrupt_mask), .timer_enable_bit(timer_enable_bit),
    .raw_interrupt_status(raw_interrupt_status),
    .masked_interrupt_status(masked_interrupt_status), .timer_interrupt(timer_interrupt),
    .current_count(current_count), .captured_count(captured_count), .pwm_out(pwm_out));

// [bench/test_gtpms_timer.sv]
// Self-checking testbench for the general-purpose timer.
`timescale 1ns/1ps
module test_gtpms_timer;
    import gtpms_pkg::*;
    // Stimulus towards the timer.
    logic        clk = 1'b0, reset = 1'b1, clk_en = 1'b0, alt = 1'b0, cap = 1'b0, run = 1'b0;
    logic        set_en = 1'b0, clr_en = 1'b0, inv = 1'b0, ld_wr = 1'b0;
    logic [2:0]  cfg = 3'h2;
    logic [1:0]  tmode = 2'h0, evt = 2'h0;
    logic [31:0] load = 32'h0, match = 32'h0, v, w;
    logic [7:0]  pre = 8'h0;
    logic [3:0]  imask = 4'h0, iclr = 4'h0, raw, msk;
    logic [8:0]  half = 9'h4;
    logic        pin, en, irq, pwm;
    logic [31:0] cnt, cap_cnt;
    int          n_fail = 0, samples_checked = 0, cycles = 0, n, k, hi;

    gtpms_timer i_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .timer_configuration(cfg),
        .alternate_mode_select(alt), .capture_mode_select(cap), .timer_mode_field(tmode),
        .timer_enable_set(set_en), .timer_enable_clear(clr_en), .edge_event_select(evt),
        .pwm_output_invert(inv), .interval_load_value(load), .interval_load_write(ld_wr),
        .match_value(match), .prescale_value(pre), .interrupt_mask(imask),
        .interrupt_clear(iclr), .capture_compare_pin(pin), .timer_enable_bit(en),
        .raw_interrupt_status(raw), .masked_interrupt_status(msk), .timer_interrupt(irq),
        .current_count(cnt), .captured_count(cap_cnt), .pwm_out(pwm));
    gtpms_pin_model i_pin (.clk(clk), .run(run), .half(half), .pin(pin));

    // Clock at 10 MHz.
    initial forever #50 clk = ~clk;

    // Cycle ceiling; the whole run needs well under a third of it.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask : tick

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask : done

    // Disable, configure, then enable; a changed setup never lands on a running timer.
    task automatic setup(input logic [2:0] c, input logic [3:0] am, input logic [31:0] ld,
                         input logic [31:0] mt);
        clr_en = 1'b1;
        tick(1);
        clr_en = 1'b0;
        cfg = c;
        {alt, cap, tmode} = am;
        load = ld;
        match = mt;
        tick(1);
        set_en = 1'b1;
        tick(1);
        set_en = 1'b0;
    endtask : setup

    task automatic clr_irq(input logic [3:0] b);
        iclr = b;
        tick(1);
        iclr = 4'h0;
    endtask : clr_irq

    task automatic reload(input logic [31:0] l);
        load = l;
        ld_wr = 1'b1;
        tick(1);
        ld_wr = 1'b0;
        chk("new load", l, cnt);
    endtask : reload

    // Toggles of the pin at four cycles apiece, then time for the synchroniser.
    task automatic toggle(input int t);
        half = 9'h4;
        run = 1'b1;
        tick(4 * t);
        run = 1'b0;
        tick(6);
    endtask : toggle

    // High output cycles in one period of load+1 cycles.
    function automatic int pwm_high(input int l, input int m, input logic iv);
        return iv ? m + 1 : l - m;
    endfunction : pwm_high

    // Qualifying edges among eight toggles that start from a low pin.
    function automatic int edges_seen(input logic [1:0] e);
        return e == GTPMS_EVT_BOTH ? 8 : (e == 2'h2 ? 0 : 4);
    endfunction : edges_seen

    initial begin
        void'($urandom(32'h864e));
        tick(5);
        reset = 1'b0;
        clk_en = 1'b1;
        imask = 4'h1;
        // One-shot then periodic 32-bit counting.
        for (k = 1; k <= 2; k++) begin
            v = $urandom_range(9, 5);
            setup(3'h0, 4'(k), v, 32'h0);
            chk("start", v, cnt);
            tick(v + 1);
            chk("reload", v, cnt);
            chk("timeout", 1, raw[GTPMS_ST_TIMEOUT]);
            chk("irq", 1, irq);
            chk("enable", k == 2, en);
            tick(3);
            chk("after", k == 2 ? v - 3 : v, cnt);
            clr_irq(4'h1);
            chk("timeout cleared", 0, {raw[0], msk[0]});
        end
        w = cnt;
        clk_en = 1'b0;
        tick(3);
        chk("frozen", w, cnt);
        clk_en = 1'b1;
        done("timer32");
        // Prescaled 16-bit timer.
        pre = 8'($urandom_range(3, 1));
        v = $urandom_range(6, 3);
        k = $urandom_range(2, 1);
        setup(3'h4, 4'(k), v, 32'h0);
        for (n = 1; n < 200 && raw[0] !== 1'b1; n++) tick(1);
        chk("span", 1, n >= v * (pre + 1) && n <= (v + 1) * (pre + 1) + 1);
        chk("stop count", v, cnt);
        chk("en16", k == 2, en);
        done("oneshot16");
        // Edge count for every edge code.
        for (k = 0; k < 4; k++) begin
            evt = 2'(k);
            n = $urandom_range(4, 1);
            v = 32'h40 + $urandom_range(15, 0);
            setup(3'h4, 4'h3, v, v - n);
            toggle(8);
            hi = n <= edges_seen(evt);
            chk("edge done", hi, raw[GTPMS_ST_MATCH]);
            chk("edge enable", !hi, en);
            chk("edge count", hi ? v : v - edges_seen(evt), cnt);
            clr_irq(4'h2);
            chk("match cleared", 0, raw[GTPMS_ST_MATCH]);
        end
        done("edge count");
        // Edge time capture and a load written mid-run.
        evt = GTPMS_EVT_RISE;
        setup(3'h4, 4'h7, 32'h100, 32'h0);
        toggle(2);
        chk("capture flag", 1, raw[GTPMS_ST_CAPTURE]);
        chk("capture value", 1, cap_cnt < 32'h100 && cap_cnt > 32'hf0);
        chk("still running", 1, en);
        reload(32'h30);
        done("edge time");
        // Waveform with both polarities; the prescale value must not matter.
        clr_irq(4'hf);
        pre = 8'h3;
        for (k = 0; k < 2; k++) begin
            inv = k[0];
            v = $urandom_range(20, 8);
            w = $urandom_range(v - 2, 1);
            setup(3'h4, 4'ha, v, w);
            hi = 0;
            repeat (v + 1) begin
                tick(1);
                hi += pwm;
            end
            chk("pwm high", pwm_high(v, w, inv), hi);
            chk("pwm flags", 0, raw);
            reload(v + 3);
        end
        done("pwm");
        // Real-time count from a 32.768 kHz pin.
        imask = 4'h8;
        half = 9'h99;
        setup(3'h1, 4'h2, 32'h0, 32'h2);
        run = 1'b1;
        for (n = 0; n < 1500 && raw[GTPMS_ST_RTC] !== 1'b1; n++) tick(1);
        chk("rtc flag", 1, raw[GTPMS_ST_RTC]);
        chk("rtc irq", 1, irq);
        chk("rtc runs", 1, en);
        clr_irq(4'h8);
        chk("rtc cleared", 0, raw[GTPMS_ST_RTC]);
        run = 1'b0;
        done("rtc");
        close_out();
    end
endmodule : test_gtpms_timer
